// ===== src/dscrf_pkg.sv
// Constants, register map and types for the core data and address register file.
// Assumes a 32-bit APB slave view; offsets are byte addresses of aligned words.
package dscrf_pkg;
    // ----------------------------------------
    // Widths
    // ----------------------------------------
    localparam int WORD_W = 16;
    localparam int EXT_W = 4;
    localparam int ACC_W = 36;
    localparam int LONG_W = 32;
    localparam int ADDR_W = 24;
    localparam int NUM_ACC = 4;
    localparam int NUM_ADR = 9;
    localparam int IDX_W = 4;
    localparam int PADDR_W = 8;

    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [7:0] OFS_IN_HIGH = 8'h00;
    localparam logic [7:0] OFS_IN_LOW = 8'h04;
    localparam logic [7:0] OFS_IN_LONG = 8'h08;
    localparam logic [7:0] OFS_IN_SINGLE = 8'h0C;
    localparam logic [7:0] OFS_ACC_BASE = 8'h10;
    localparam logic [7:0] OFS_ACC_STRIDE = 8'h14;
    localparam logic [7:0] OFS_ADR_BASE = 8'h60;
    localparam logic [7:0] OFS_STACK_PTR = 8'h7C;
    localparam logic [7:0] OFS_STATUS = 8'h88;
    localparam logic [7:0] OFS_LAST = 8'h88;
    // Word slots inside one accumulator group
    localparam logic [2:0] SUB_EXT = 3'h0;
    localparam logic [2:0] SUB_UPR = 3'h1;
    localparam logic [2:0] SUB_LWR = 3'h2;
    localparam logic [2:0] SUB_LONG = 3'h3;
    localparam logic [2:0] SUB_FULL = 3'h4;

    // ----------------------------------------
    // Address unit slots and shadow sets
    // ----------------------------------------
    localparam logic [IDX_W-1:0] ADR_PTR3 = 4'h3;
    localparam logic [IDX_W-1:0] ADR_SECOND = 4'h7;
    localparam logic [IDX_W-1:0] ADR_MODULO = 4'h8;
    localparam logic [NUM_ADR-1:0] ADR_NARROW = 9'h180;
    localparam logic [NUM_ADR-1:0] SHADOW_BASE = 9'h143;
    localparam logic [NUM_ADR-1:0] SHADOW_EXT = 9'h1FF;

    // ----------------------------------------
    // Reset values and field positions
    // ----------------------------------------
    localparam logic [WORD_W-1:0] MODULO_LINEAR = 16'hFFFF;
    localparam logic [ADDR_W-1:0] ADR_RESET = 24'h000000;
    localparam int STAT_FI_LSB = 0;
    localparam int STAT_EXT_BIT = 2;
    localparam int STAT_MOD_BIT = 3;

    typedef enum logic [1:0] {
        FI_NORMAL = 2'b00,
        FI_PUSH = 2'b01,
        FI_ACTIVE = 2'b11
    } dscrf_fi_t;

    typedef logic [ADDR_W-1:0] dscrf_addr_t;
    typedef logic [ACC_W-1:0] dscrf_acc_t;
endpackage : dscrf_pkg

// ===== src/dscrf_core_if.sv
// Carrier between the register file top and its accumulator and shadow banks.
// Assumes all parties run on pclk with the same clock enable.
`timescale 1ns/100ps
interface dscrf_core_if;
    import dscrf_pkg::*;
    logic acc_wr;
    logic [1:0] acc_sel;
    logic [2:0] acc_sub;
    logic [LONG_W-1:0] acc_wdata;
    logic acc_load;
    dscrf_acc_t acc_ldata;
    dscrf_acc_t acc_q [NUM_ACC];
    logic swap;
    dscrf_addr_t live [NUM_ADR];
    dscrf_addr_t shadow [NUM_ADR];

    modport top (output acc_wr, acc_sel, acc_sub, acc_wdata, acc_load, acc_ldata, swap, live,
        input acc_q, shadow);
    modport acc (input acc_wr, acc_sel, acc_sub, acc_wdata, acc_load, acc_ldata, output acc_q);
    modport shd (input swap, live, output shadow);
endinterface : dscrf_core_if

// ===== src/dscrf_acc_bank.sv
// Four 36-bit accumulators with extension, upper, lower, long and full views.
// Assumes one write source per cycle; a datapath load outranks a register write.
`timescale 1ns/100ps
module dscrf_acc_bank (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    dscrf_core_if.acc bus
);
    import dscrf_pkg::*;

    dscrf_acc_t acc [NUM_ACC];

    // ----------------------------------------
    // Merge one view write into an accumulator
    // ----------------------------------------
    function automatic dscrf_acc_t merge(input dscrf_acc_t cur, input logic [2:0] sub,
        input logic [LONG_W-1:0] v);
        dscrf_acc_t r;
        r = cur;
        case (sub)
            SUB_EXT: r[ACC_W-1:LONG_W] = v[EXT_W-1:0];
            SUB_UPR: r[LONG_W-1:WORD_W] = v[WORD_W-1:0];
            SUB_LWR: r[WORD_W-1:0] = v[WORD_W-1:0];
            SUB_LONG: r[LONG_W-1:0] = v;
            // Full view through a 32-bit port: extension follows the sign
            SUB_FULL: r = {{EXT_W{v[LONG_W-1]}}, v};
            default: r = cur;
        endcase
        return r;
    endfunction : merge

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < NUM_ACC; i++) begin
                acc[i] <= '0;
            end
        end else if (ce) begin
            if (bus.acc_load) begin
                acc[bus.acc_sel] <= bus.acc_ldata;
            end else if (bus.acc_wr) begin
                acc[bus.acc_sel] <= merge(acc[bus.acc_sel], bus.acc_sub, bus.acc_wdata);
            end
        end
    end

    assign bus.acc_q = acc;
endmodule : dscrf_acc_bank

// ===== src/dscrf_shadow.sv
// Shadow copies of the address unit registers for fast interrupt processing.
// Assumes the top swaps live values on the same swap pulse.
`timescale 1ns/100ps
module dscrf_shadow #(
    parameter logic [dscrf_pkg::NUM_ADR-1:0] SHADOW_MASK = dscrf_pkg::SHADOW_BASE
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    dscrf_core_if.shd bus
);
    import dscrf_pkg::*;

    dscrf_addr_t copy [NUM_ADR];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < NUM_ADR; i++) begin
                copy[i] <= ADR_RESET;
            end
        end else if (ce && bus.swap) begin
            for (int i = 0; i < NUM_ADR; i++) begin
                if (SHADOW_MASK[i]) begin
                    copy[i] <= bus.live[i];
                end
            end
        end
    end

    assign bus.shadow = copy;
endmodule : dscrf_shadow

// ===== src/dscrf_regfile.sv
// Core data and address register file with an APB register view.
// Summary of operation
// - The 32-bit input pair is two separately reachable 16-bit halves.
// - Fast interrupt entry pushes the 32-bit input pair onto the stack.
// - Each accumulator has its own 4-bit extension for bits 35 to 32.
// - Each accumulator has its own 16-bit upper part for bits 31 to 16.
// - Each accumulator has its own 16-bit lower part for bits 15 to 0.
// - Each accumulator has a 32-bit long view of its upper and lower parts.
// - There are four 36-bit accumulators made of extension, upper and lower parts.
// - Pointers 0 and 1, the offset and the modulo modifier are always shadowed.
// - The extended variant also shadows pointers 2 to 5 and the second read offset.
// - There are six 24-bit pointers, a 24-bit stack pointer and a 24-bit offset.
// - The second read offset, sign-extended, updates pointer 3 on a dual read.
// - The modulo modifier selects modulo or linear arithmetic on pointers 0 and 1.
// Assumes APB master on pclk; core strobes are one-cycle pulses qualified by ce.
//
// Decided for this implementation: the register offsets and the APB register port.
`timescale 1ns/100ps
module dscrf_regfile #(
    parameter bit EXTENDED = 1'b1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [dscrf_pkg::PADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic fi_enter,
    input wire logic fi_return,
    output logic push_valid,
    output logic [dscrf_pkg::LONG_W-1:0] push_data,
    input wire logic push_ready,
    input wire logic dual_read,
    input wire logic ptr_step,
    input wire logic ptr_sel,
    input wire logic [dscrf_pkg::ADDR_W-1:0] ptr_delta,
    input wire logic acc_load,
    input wire logic [1:0] acc_load_sel,
    input wire logic [dscrf_pkg::ACC_W-1:0] acc_load_data,
    output logic [dscrf_pkg::ADDR_W-1:0] ptr0,
    output logic [dscrf_pkg::ADDR_W-1:0] ptr1,
    output logic [dscrf_pkg::ADDR_W-1:0] ptr3,
    output logic modulo_active,
    output logic [dscrf_pkg::ACC_W-1:0] acc_first
);
    import dscrf_pkg::*;

    localparam logic [NUM_ADR-1:0] SHADOW_MASK = EXTENDED ? SHADOW_EXT : SHADOW_BASE;

    // ----------------------------------------
    // Storage
    // ----------------------------------------
    logic [WORD_W-1:0] in_high;
    logic [WORD_W-1:0] in_low;
    logic [WORD_W-1:0] in_single;
    dscrf_addr_t adr [NUM_ADR];
    dscrf_addr_t stack_pointer;
    dscrf_fi_t fi_state;
    dscrf_fi_t next_fi_state;
    logic rd_ok;
    logic swap;
    dscrf_core_if core_bus ();

    // ----------------------------------------
    // Address decode
    // ----------------------------------------
    logic in_acc;
    logic in_adr;
    logic [PADDR_W-1:0] acc_off;
    logic [1:0] acc_idx;
    logic [2:0] acc_sub;
    logic [IDX_W-1:0] adr_idx;
    logic mapped;
    logic wr_fire;

    always_comb begin
        acc_off = paddr - OFS_ACC_BASE;
        in_acc = (paddr >= OFS_ACC_BASE) && (paddr < OFS_ADR_BASE);
        // Stack pointer sits inside the slot range, so later slots skip it
        in_adr = (paddr >= OFS_ADR_BASE) && (paddr < OFS_STATUS) && (paddr != OFS_STACK_PTR);
        acc_idx = 2'(acc_off / OFS_ACC_STRIDE);
        acc_sub = 3'((acc_off % OFS_ACC_STRIDE) >> 2);
        adr_idx = IDX_W'((paddr - OFS_ADR_BASE - (paddr > OFS_STACK_PTR ? 8'h04 : 8'h00)) >> 2);
        mapped = (paddr[1:0] == 2'h0) && (paddr <= OFS_LAST);
    end

    assign wr_fire = psel && penable && pwrite && pready && mapped;

    // ----------------------------------------
    // Modulo and sign helpers
    // ----------------------------------------
    function automatic dscrf_addr_t sext16(input logic [WORD_W-1:0] v);
        return {{(ADDR_W - WORD_W){v[WORD_W-1]}}, v};
    endfunction : sext16

    // Modulus is modifier+1 in an aligned block; steps beyond it are not corrected
    function automatic dscrf_addr_t mod_add(input dscrf_addr_t p, input dscrf_addr_t st,
        input logic [WORD_W-1:0] mdf);
        dscrf_addr_t mask;
        dscrf_addr_t base;
        dscrf_addr_t m;
        logic signed [ADDR_W:0] off;
        m = {{(ADDR_W - WORD_W){1'b0}}, mdf & 16'h7FFF};
        mask = '0;
        for (int i = 0; i < ADDR_W; i++) begin
            if (mask < m) begin
                mask = {mask[ADDR_W-2:0], 1'b1};
            end
        end
        base = p & ~mask;
        off = $signed({1'b0, p & mask}) + $signed({st[ADDR_W-1], st});
        if (off > $signed({1'b0, m})) begin
            off = off - $signed({1'b0, m}) - 25'sh1;
        end else if (off < 0) begin
            off = off + $signed({1'b0, m}) + 25'sh1;
        end
        return base + off[ADDR_W-1:0];
    endfunction : mod_add

    assign modulo_active = adr[ADR_MODULO][WORD_W-1:0] != MODULO_LINEAR;

    // ----------------------------------------
    // Fast interrupt sequencing
    // ----------------------------------------
    always_comb begin
        next_fi_state = fi_state;
        swap = 1'b0;
        case (fi_state)
            FI_NORMAL: begin
                if (fi_enter) begin
                    next_fi_state = FI_PUSH;
                    swap = 1'b1;
                end
            end
            FI_PUSH: begin
                if (push_ready) begin
                    next_fi_state = FI_ACTIVE;
                end
            end
            FI_ACTIVE: begin
                if (fi_return) begin
                    next_fi_state = FI_NORMAL;
                    swap = 1'b1;
                end
            end
            default: next_fi_state = FI_NORMAL;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fi_state <= FI_NORMAL;
        end else if (ce) begin
            fi_state <= next_fi_state;
        end
    end

    // Snapshot at entry, so later writes cannot tear the pushed pair
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            push_data <= '0;
        end else if (ce && fi_state == FI_NORMAL && fi_enter) begin
            push_data <= {in_high, in_low};
        end
    end

    assign push_valid = fi_state == FI_PUSH;

    // ----------------------------------------
    // Input registers
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            in_high <= '0;
            in_low <= '0;
            in_single <= '0;
        end else if (ce && wr_fire) begin
            case (paddr)
                OFS_IN_HIGH: in_high <= pwdata[WORD_W-1:0];
                OFS_IN_LOW: in_low <= pwdata[WORD_W-1:0];
                OFS_IN_LONG: begin
                    in_high <= pwdata[LONG_W-1:WORD_W];
                    in_low <= pwdata[WORD_W-1:0];
                end
                OFS_IN_SINGLE: in_single <= pwdata[WORD_W-1:0];
                default: ;
            endcase
        end
    end

    // ----------------------------------------
    // Address unit registers
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < NUM_ADR; i++) begin
                adr[i] <= ADR_RESET;
            end
            adr[ADR_MODULO] <= ADDR_W'(MODULO_LINEAR);
            stack_pointer <= ADR_RESET;
        end else if (ce) begin
            if (swap) begin
                for (int i = 0; i < NUM_ADR; i++) begin
                    if (SHADOW_MASK[i]) begin
                        adr[i] <= core_bus.shadow[i];
                    end
                end
            end else begin
                if (dual_read) begin
                    adr[ADR_PTR3] <= adr[ADR_PTR3] + sext16(adr[ADR_SECOND][WORD_W-1:0]);
                end
                if (ptr_step) begin
                    if (modulo_active) begin
                        adr[ptr_sel] <= mod_add(adr[ptr_sel], ptr_delta,
                            adr[ADR_MODULO][WORD_W-1:0]);
                    end else begin
                        adr[ptr_sel] <= adr[ptr_sel] + ptr_delta;
                    end
                end
                // Software write wins over a same-cycle pointer step or dual read
                if (wr_fire && in_adr) begin
                    adr[adr_idx] <= ADR_NARROW[adr_idx]
                        ? ADDR_W'(pwdata[WORD_W-1:0])
                        : pwdata[ADDR_W-1:0];
                end
                if (wr_fire && paddr == OFS_STACK_PTR) begin
                    stack_pointer <= pwdata[ADDR_W-1:0];
                end
            end
        end
    end

    // ----------------------------------------
    // Banks
    // ----------------------------------------
    assign core_bus.acc_wr = wr_fire && in_acc;
    assign core_bus.acc_sel = acc_load ? acc_load_sel : acc_idx;
    assign core_bus.acc_sub = acc_sub;
    assign core_bus.acc_wdata = pwdata;
    assign core_bus.acc_load = acc_load;
    assign core_bus.acc_ldata = acc_load_data;
    assign core_bus.swap = swap;
    assign core_bus.live = adr;

    dscrf_acc_bank u_acc (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .bus(core_bus)
    );

    dscrf_shadow #(
        .SHADOW_MASK(SHADOW_MASK)
    ) u_shadow (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .bus(core_bus)
    );

    // ----------------------------------------
    // Read path
    // ----------------------------------------
    function automatic logic [31:0] acc_view(input dscrf_acc_t a, input logic [2:0] sub);
        case (sub)
            SUB_EXT: return {28'h0000000, a[ACC_W-1:LONG_W]};
            SUB_UPR: return {16'h0000, a[LONG_W-1:WORD_W]};
            SUB_LWR: return {16'h0000, a[WORD_W-1:0]};
            SUB_LONG: return a[LONG_W-1:0];
            // Full view reads bits 31:0; extension is read alone
            SUB_FULL: return a[LONG_W-1:0];
            default: return 32'h00000000;
        endcase
    endfunction : acc_view

    logic [31:0] rd_value;

    always_comb begin
        rd_value = 32'h00000000;
        if (in_acc) begin
            rd_value = acc_view(core_bus.acc_q[acc_idx], acc_sub);
        end else if (in_adr) begin
            rd_value = {8'h00, adr[adr_idx]};
        end else begin
            case (paddr)
                OFS_IN_HIGH: rd_value = {16'h0000, in_high};
                OFS_IN_LOW: rd_value = {16'h0000, in_low};
                OFS_IN_LONG: rd_value = {in_high, in_low};
                OFS_IN_SINGLE: rd_value = {16'h0000, in_single};
                OFS_STACK_PTR: rd_value = {8'h00, stack_pointer};
                OFS_STATUS: begin
                    rd_value[STAT_FI_LSB +: 2] = fi_state;
                    rd_value[STAT_EXT_BIT] = EXTENDED;
                    rd_value[STAT_MOD_BIT] = modulo_active;
                end
                default: ;
            endcase
        end
    end

    // Read data is captured in setup, so access needs no wait state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
            rd_ok <= 1'b0;
            pslverr <= 1'b0;
        end else if (ce) begin
            rd_ok <= psel && !(penable && pready);
            if (psel) begin
                prdata <= rd_value;
                pslverr <= !mapped || (pwrite && paddr == OFS_STATUS);
            end
        end
    end

    assign pready = ce && rd_ok;

    assign ptr0 = adr[0];
    assign ptr1 = adr[1];
    assign ptr3 = adr[ADR_PTR3];
    assign acc_first = core_bus.acc_q[0];
endmodule : dscrf_regfile

// ===== verification/dscrf_properties.sv
// Concurrent checks on the register file top ports.
// Assumes pclk and presetn of the top; bound to it after the module.
`timescale 1ns/100ps
module dscrf_properties (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [dscrf_pkg::PADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic fi_enter,
    input wire logic fi_return,
    input wire logic push_valid,
    input wire logic [dscrf_pkg::LONG_W-1:0] push_data,
    input wire logic push_ready,
    input wire logic ptr_step,
    input wire logic ptr_sel,
    input wire logic [dscrf_pkg::ADDR_W-1:0] ptr_delta,
    input wire logic acc_load,
    input wire logic [1:0] acc_load_sel,
    input wire logic [dscrf_pkg::ACC_W-1:0] acc_load_data,
    input wire logic [dscrf_pkg::ADDR_W-1:0] ptr0,
    input wire logic modulo_active,
    input wire logic [dscrf_pkg::ACC_W-1:0] acc_first
);
    import dscrf_pkg::*;
    // Mirror of the interrupt state
    logic [1:0] fi_st;
    logic [31:0] last_wdata;
    dscrf_acc_t last_acc;
    logic wr;
    logic aw;
    assign wr = psel & penable & pwrite & pready;
    assign aw = wr & ~(acc_load & (acc_load_sel == 2'h0));
    always_ff @(posedge pclk) begin
        last_wdata <= pwdata;
        last_acc <= acc_first;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fi_st <= 2'h0;
        end else if (ce && fi_st == 2'h0 && fi_enter) begin
            fi_st <= 2'h1;
        end else if (ce && fi_st == 2'h1 && push_valid && push_ready) begin
            fi_st <= 2'h2;
        end else if (ce && fi_st == 2'h2 && fi_return) begin
            fi_st <= 2'h0;
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ----------------------------------------
    // Checks
    // ----------------------------------------
    chk_push_after_entry: assert property (
        ce && fi_enter && fi_st == 2'h0 |=> push_valid) else $error("no push after entry");
    chk_push_word_held: assert property (
        push_valid && !(ce && push_ready) |=> push_valid && $stable(push_data))
        else $error("push word dropped");
    chk_push_only_pending: assert property (
        fi_st != 2'h1 |-> !push_valid) else $error("push outside entry");
    chk_ptr_write_lands: assert property (
        wr && paddr == 8'h60 && !fi_enter |=> ptr0 == last_wdata[23:0])
        else $error("pointer write lost");
    chk_step_linear_add: assert property (
        ce && ptr_step && !ptr_sel && !modulo_active && !fi_enter && !fi_return
        && !(wr && paddr == 8'h60) |=> ptr0 == $past(ptr0) + $past(ptr_delta))
        else $error("linear step wrong");
    chk_acc_load_full: assert property (
        ce && acc_load && acc_load_sel == 2'h0 |=> acc_first == $past(acc_load_data))
        else $error("accumulator load wrong");
    chk_ext_write_only: assert property (
        aw && paddr == 8'h10 |=> acc_first == {last_wdata[3:0], last_acc[31:0]})
        else $error("extension write wrong");
    chk_long_write_keeps: assert property (
        aw && paddr == 8'h1C |=> acc_first == {last_acc[35:32], last_wdata})
        else $error("long write wrong");
    chk_full_write_sign: assert property (
        aw && paddr == 8'h20 |=> acc_first == {{4{last_wdata[31]}}, last_wdata})
        else $error("full write wrong");
    cov_push_done: cover property (push_valid && push_ready && ce);
    cov_full_write: cover property (aw && paddr == 8'h20);
    cov_step: cover property (ce && ptr_step && !modulo_active);
endmodule : dscrf_properties

bind dscrf_regfile dscrf_properties u_props (.*);

// ===== verification/dscrf_stack_model.sv
// Stack side that takes the pushed input pair after a set delay.
// Assumes the register file's clock and reset; the bench sets the delay.
`timescale 1ns/100ps
module dscrf_stack_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [3:0] delay,
    input wire logic push_valid,
    input wire logic [dscrf_pkg::LONG_W-1:0] push_data,
    output logic push_ready,
    output logic [dscrf_pkg::LONG_W-1:0] last_word,
    output logic [7:0] n_words
);
    import dscrf_pkg::*;
    logic [3:0] wait_cnt;
    assign push_ready = push_valid && (wait_cnt >= delay);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wait_cnt <= 4'h0;
            last_word <= '0;
            n_words <= 8'h00;
        end else if (push_valid && push_ready) begin
            wait_cnt <= 4'h0;
            last_word <= push_data;
            n_words <= n_words + 8'h01;
        end else if (push_valid) begin
            wait_cnt <= wait_cnt + 4'h1;
        end
    end
endmodule : dscrf_stack_model

// ===== verification/testbench.sv
// Self-checking bench for the register file, APB master and core strobes.
// Assumes the stack model on the push port; ce held high throughout.
`timescale 1ns/100ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_fail++; \
    $display("unexpected %s expected %h seen %h", nm, e, g); end end
module testbench;
    import dscrf_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic ce = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [PADDR_W-1:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic pready, pslverr, push_valid, push_ready, modulo_active, e;
    logic [LONG_W-1:0] push_data, last_word;
    logic fi_enter = 1'b0, fi_return = 1'b0, dual_read = 1'b0, ptr_step = 1'b0;
    logic ptr_sel = 1'b0, acc_load = 1'b0;
    logic [1:0] acc_load_sel = 2'h0;
    logic [3:0] delay = 4'h0;
    logic [7:0] n_words;
    dscrf_addr_t ptr_delta = 24'h0, ptr0, ptr1, ptr3;
    dscrf_acc_t acc_load_data = 36'h0, acc_first;
    int n_fail = 0;
    int samples_checked = 0;
    dscrf_regfile #(.EXTENDED(1'b1)) dut (.*);
    dscrf_stack_model stack (.*);
    always #50 pclk = ~pclk;
    // ----------------------------------------
    // Bus and strobe tasks
    // ----------------------------------------
    task automatic tally_and_finish();
        if (n_fail == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : tally_and_finish
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v);
        int j;
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, v};
        @(posedge pclk);
        penable <= 1'b1;
        for (j = 0; j < 16; j++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (j == 16) begin
            n_fail++;
            tally_and_finish();
        end
        {q, e} = {prdata, pslverr};
        {psel, penable} <= 2'b00;
        @(negedge pclk);
    endtask : apb
    task automatic rdc(input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        `CHK($sformatf("read %h", a), x, q)
    endtask : rdc
    task automatic strobe(input logic [4:0] s, input logic [1:0] sel, input dscrf_addr_t dl,
            input dscrf_acc_t ld);
        @(posedge pclk);
        {fi_enter, fi_return, dual_read, ptr_step, acc_load} <= s;
        {ptr_sel, acc_load_sel, ptr_delta, acc_load_data} <= {sel[0], sel, dl, ld};
        @(posedge pclk);
        {fi_enter, fi_return, dual_read, ptr_step, acc_load} <= 5'h00;
        @(negedge pclk);
    endtask : strobe
    task automatic wait_push(input logic [7:0] k);
        int j;
        for (j = 0; j < 16 && n_words !== k; j++) @(negedge pclk);
        if (j == 16) begin
            n_fail++;
            tally_and_finish();
        end
    endtask : wait_push
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_pair();
        rdc(8'h88, 32'h00000004);
        `CHK("modulo_active", 1'b0, modulo_active)
        apb(1'b1, 8'h00, 32'hFFFF1234);
        apb(1'b1, 8'h04, 32'h00005678);
        rdc(8'h08, 32'h12345678);
        apb(1'b1, 8'h08, 32'hAABBCCDD);
        rdc(8'h00, 32'h0000AABB);
        rdc(8'h04, 32'h0000CCDD);
        apb(1'b0, 8'h8C, 32'h0);
        `CHK("unmapped error", 1'b1, e)
    endtask : t_pair
    task automatic t_acc();
        logic [7:0] g;
        for (int i = 0; i < NUM_ACC; i++) begin
            g = 8'h10 + 8'(i * 20);
            apb(1'b1, g, 32'hFFFFFFF5 + 32'(i));
            apb(1'b1, g + 8'h04, 32'hFFFF1110 + 32'(i));
            apb(1'b1, g + 8'h08, 32'h00002220 + 32'(i));
            rdc(g, 32'h5 + 32'(i));
            rdc(g + 8'h0C, {16'h1110 + 16'(i), 16'h2220 + 16'(i)});
            apb(1'b1, g + 8'h0C, 32'h89ABCDEF);
            rdc(g + 8'h04, 32'h000089AB);
            rdc(g + 8'h08, 32'h0000CDEF);
            apb(1'b1, g + 8'h10, 32'h80000001);
            rdc(g, 32'hF);
        end
        `CHK("acc_first", 36'hF80000001, acc_first)
        strobe(5'h01, 2'h0, 24'h0, 36'h912345678);
        `CHK("acc_first", 36'h912345678, acc_first)
        strobe(5'h01, 2'h3, 24'h0, 36'h700000001);
        rdc(8'h4C, 32'h7);
    endtask : t_acc
    task automatic t_ptr();
        apb(1'b1, 8'h60, 32'hFF123456);
        apb(1'b1, 8'h64, 32'h00001000);
        apb(1'b1, 8'h6C, 32'h00ABCDEF);
        apb(1'b1, 8'h7C, 32'h00000777);
        apb(1'b1, 8'h80, 32'h0000FFFE);
        `CHK("ptr0", 24'h123456, ptr0)
        rdc(8'h7C, 32'h777);
        strobe(5'h02, 2'h0, 24'hFFFFFE, 36'h0);
        `CHK("ptr0", 24'h123454, ptr0)
        strobe(5'h02, 2'h1, 24'h000010, 36'h0);
        `CHK("ptr1", 24'h001010, ptr1)
        strobe(5'h04, 2'h0, 24'h0, 36'h0);
        `CHK("ptr3", 24'hABCDED, ptr3)
    endtask : t_ptr
    task automatic t_fast();
        strobe(5'h08, 2'h0, 24'h0, 36'h0);
        `CHK("ptr0", 24'h123454, ptr0)
        delay <= 4'h3;
        strobe(5'h10, 2'h0, 24'h0, 36'h0);
        `CHK("push_valid", 1'b1, push_valid)
        `CHK("ptr0", 24'h000000, ptr0)
        `CHK("ptr3", 24'h000000, ptr3)
        wait_push(8'h01);
        `CHK("pushed pair", 32'hAABBCCDD, last_word)
        apb(1'b0, 8'h88, 32'h0);
        `CHK("fi state", 3'h7, q[2:0])
        apb(1'b1, 8'h60, 32'h00000222);
        strobe(5'h08, 2'h0, 24'h0, 36'h0);
        `CHK("ptr1", 24'h001010, ptr1)
        `CHK("ptr3", 24'hABCDED, ptr3)
        delay <= 4'h0;
        strobe(5'h10, 2'h0, 24'h0, 36'h0);
        `CHK("ptr0", 24'h000222, ptr0)
        wait_push(8'h02);
        strobe(5'h08, 2'h0, 24'h0, 36'h0);
        `CHK("ptr0", 24'h123454, ptr0)
    endtask : t_fast
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_pair();
        t_acc();
        t_ptr();
        t_fast();
        tally_and_finish();
    end
endmodule : testbench
